//--- bench/rff_properties.sv
// checker on the receive filter top ports
`include "rff_map.svh"
`timescale 1ns/1ps
module rff_properties (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rx_valid,
  input wire logic        rx_sof,
  input wire logic        rx_eof,
  input wire logic        pause_rx,
  input wire logic [7:0]  q_data,
  input wire logic        q_last,
  input wire logic        q_valid,
  input wire logic        q_ready,
  input wire logic        tx_hold,
  input wire logic        rx_running
);
  // one clock domain, so one clocking and one disable
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_RUN_START: assert property (
    reg_wr && reg_addr == `RFF_OFS_RX_CTRL && reg_wdata[0] |-> ##[1:4] rx_running)
    else $error("receive did not start after enable write");
  AST_RUN_HOLD: assert property (
    rx_running && reg_wr && reg_addr == `RFF_OFS_RX_CTRL && !reg_wdata[0]
      && rx_valid && !rx_eof |=> rx_running)
    else $error("receive stopped in mid frame");
  AST_STOP_IDLE: assert property (
    $fell(rx_running) |-> !$past(rx_valid) || $past(rx_eof) || $past(rx_sof))
    else $error("receive stopped while a byte was mid frame");
  AST_HOLD_CAUSE: assert property (
    $rose(tx_hold) |-> $past(pause_rx) || $past(pause_rx, 2))
    else $error("transmit hold rose without a pause request");
  AST_HOLD_MIN: assert property (
    $rose(tx_hold) |=> tx_hold [*8])
    else $error("transmit hold dropped too early");
  AST_Q_STABLE: assert property (
    q_valid && !q_ready |=> q_valid && $stable(q_data) && $stable(q_last))
    else $error("queue output changed while stalled");
  AST_FREE_FIELD: assert property (
    reg_rd && reg_addr == `RFF_OFS_TXQ_FREE |=> reg_rdata[15:13] == 3'h0)
    else $error("free byte count wider than its field");
  AST_RDATA_QUIET: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data present without a read");
endmodule // rff_properties

bind rff_top rff_properties u_rff_properties (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
  .pause_rx(pause_rx), .q_data(q_data), .q_last(q_last), .q_valid(q_valid),
  .q_ready(q_ready), .tx_hold(tx_hold), .rx_running(rx_running));

//--- bench/rff_station_model.sv
// remote station model driving byte-wide frames into the receive port
`timescale 1ns/1ps
module rff_station_model (
  input  wire logic clk_sys,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  output logic       rx_sof,
  output logic       rx_eof,
  output logic       rx_fcs_bad,
  output logic       rx_hash_hit
);
  // quiet line at time zero
  initial begin
    rx_data = 8'h5A;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_fcs_bad = 1'b0;
    rx_hash_hit = 1'b0;
  end
  // destination first, then filler; the last four bytes stand for the fcs
  task automatic send(input logic [47:0] dest, input int n, input logic bad, input logic hit);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_valid    <= 1'b1;
      rx_data     <= (i < 6) ? dest[47-8*i -: 8] : 8'h20 + i[7:0];
      rx_sof      <= (i == 0);
      rx_eof      <= (i == n - 1);
      rx_fcs_bad  <= bad && (i == n - 1);
      rx_hash_hit <= hit;
    end
    @(posedge clk_sys);
    rx_valid    <= 1'b0;
    rx_eof      <= 1'b0;
    rx_fcs_bad  <= 1'b0;
    rx_hash_hit <= 1'b0;
    // released line: never leave the last byte standing
    rx_data     <= ~rx_data;
  endtask
endmodule // rff_station_model

//--- bench/tb_rff_top.sv
// self-checking bench: registers, address filters, pause and queue stall
`include "rff_map.svh"
`timescale 1ns/1ps
module tb_rff_top;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF; // broadcast
  localparam logic [47:0] ST = 48'h0202_0202_0202; // station, byte order free
  localparam logic [47:0] MC = 48'h0300_0000_0001; // group bit set
  localparam logic [47:0] UC = 48'h0400_0000_0001; // foreign unicast
  logic        clk_sys, rst_b, reg_wr, reg_rd, pause_rx, tx_frame_done, q_ready;
  logic [7:0]  reg_addr, rx_data, q_data;
  logic [15:0] reg_wdata, reg_rdata, pause_quanta;
  logic [12:0] tx_frame_bytes;
  logic        rx_valid, rx_sof, rx_eof, rx_fcs_bad, rx_hash_hit;
  logic        q_last, q_valid, rx_overflow, tx_hold, rx_running;
  logic [7:0]  last_byte;         // byte that carried the end marker
  logic        ovf = 1'b0;        // sticky overflow seen
  int          frames = 0;        // end markers taken
  int          qbytes = 0;        // bytes taken from the queue
  int          fails = 0;
  int          checked = 0;
  rff_top u_rff_top (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_fcs_bad(rx_fcs_bad), .rx_hash_hit(rx_hash_hit), .pause_rx(pause_rx),
    .pause_quanta(pause_quanta), .tx_frame_done(tx_frame_done),
    .tx_frame_bytes(tx_frame_bytes), .q_data(q_data), .q_last(q_last),
    .q_valid(q_valid), .q_ready(q_ready), .rx_overflow(rx_overflow),
    .tx_hold(tx_hold), .rx_running(rx_running));
  rff_station_model u_rff_station_model (.clk_sys(clk_sys), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_fcs_bad(rx_fcs_bad),
    .rx_hash_hit(rx_hash_hit));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // frame end counter on the queue side
  always @(posedge clk_sys) begin
    if (q_valid && q_ready) begin
      qbytes <= qbytes + 1;
    end
    if (q_valid && q_ready && q_last) begin
      frames    <= frames + 1;
      last_byte <= q_data;
    end
    if (rx_overflow) begin
      ovf <= 1'b1;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // program control, send a 12-byte frame, compare end markers and last byte
  task automatic fc(input logic [15:0] ctl, input logic [47:0] dest, input logic bad,
                    input logic hit, input int dlt, input logic [7:0] lb);
    int n0;
    int b0;
    wr(`RFF_OFS_RX_CTRL, ctl);
    n0 = frames;
    b0 = qbytes;
    u_rff_station_model.send(dest, 12, bad, hit);
    // delay line plus fifo plus output stage, with margin
    repeat (40) @(posedge clk_sys);
    check(16'(frames - n0), 16'(dlt));
    if (dlt != 0) begin
      check({8'h00, last_byte}, {8'h00, lb});
      // strip keeps 8 of 12 bytes, store keeps all 12 (fcs after data)
      check(16'(qbytes - b0), ctl[`RFF_BIT_DROP_FCS_EN] ? 16'h0008 : 16'h000C);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 1500 cycles the run needs
  initial begin
    #200000;
    fails++;
    test_done;
  end
  initial begin
    int n0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, pause_rx, tx_frame_done} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pause_quanta = 16'h0000;
    tx_frame_bytes = 13'h0000;
    q_ready = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(`RFF_OFS_RX_CTRL, 16'h0000);
    rd_chk(`RFF_OFS_TXQ_FREE, 16'h1000);
    rd_chk(8'h40, 16'h0000);
    wr(`RFF_OFS_TXQ_FREE, 16'h0000);
    rd_chk(`RFF_OFS_TXQ_FREE, 16'h1000);
    wr(`RFF_OFS_RX_CTRL, 16'hFFFF);
    rd_chk(`RFF_OFS_RX_CTRL, 16'h06FD);
    // pause honour only with full duplex selected first
    wr(`RFF_OFS_LINK_CFG, 16'h0001);
    wr(`RFF_OFS_RX_CTRL, 16'h0401);
    @(posedge clk_sys);
    pause_rx     <= 1'b1;
    pause_quanta <= 16'h0001;
    @(posedge clk_sys);
    pause_rx     <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check({15'h0, tx_hold}, 16'h0001);
    repeat (600) @(posedge clk_sys);
    check({15'h0, tx_hold}, 16'h0000);
    // software looks at free space before reserving
    rd_chk(`RFF_OFS_TXQ_FREE, 16'h1000);
    wr(`RFF_OFS_TXQ_CMD, 16'h0064);
    rd_chk(`RFF_OFS_TXQ_FREE, 16'h0F98);
    @(posedge clk_sys);
    tx_frame_done  <= 1'b1;
    tx_frame_bytes <= 13'h0064;
    @(posedge clk_sys);
    tx_frame_done  <= 1'b0;
    rd_chk(`RFF_OFS_TXQ_FREE, 16'h1000);
    wr(`RFF_OFS_STATION_LO, 16'h0202);
    wr(`RFF_OFS_STATION_MID, 16'h0202);
    wr(`RFF_OFS_STATION_HI, 16'h0202);
    // filter table: strip off keeps fcs (0x2B last), strip on ends at 0x27
    fc(16'h0081, BC, 1'b0, 1'b0, 1, 8'h2B);
    fc(16'h0081, ST, 1'b0, 1'b0, 0, 8'h00);
    fc(16'h00A1, BC, 1'b0, 1'b0, 1, 8'h2B);
    fc(16'h00A9, ST, 1'b0, 1'b0, 1, 8'h27);
    fc(16'h0041, BC, 1'b0, 1'b0, 1, 8'h2B);
    fc(16'h0049, MC, 1'b0, 1'b0, 1, 8'h27);
    fc(16'h0005, MC, 1'b0, 1'b1, 1, 8'h2B);
    fc(16'h0005, MC, 1'b0, 1'b0, 0, 8'h00);
    fc(16'h0011, UC, 1'b0, 1'b0, 1, 8'h2B);
    fc(16'h0081, BC, 1'b1, 1'b0, 1, 8'h00);
    fc(16'h0281, BC, 1'b1, 1'b0, 1, 8'h2B);
    fc(16'h0080, BC, 1'b0, 1'b0, 0, 8'h00);
    // enable cleared in mid frame: this frame still completes
    wr(`RFF_OFS_RX_CTRL, 16'h0081);
    n0 = frames;
    fork
      u_rff_station_model.send(BC, 12, 1'b0, 1'b0);
      begin
        repeat (4) @(posedge clk_sys);
        wr(`RFF_OFS_RX_CTRL, 16'h0080);
      end
    join
    repeat (40) @(posedge clk_sys);
    check(16'(frames - n0), 16'h0001);
    check({15'h0, rx_running}, 16'h0000);
    // consumer stalls: a long frame overruns the fifo, then drains
    q_ready <= 1'b0;
    wr(`RFF_OFS_RX_CTRL, 16'h0081);
    u_rff_station_model.send(BC, 40, 1'b0, 1'b0);
    repeat (5) @(posedge clk_sys);
    check({15'h0, ovf}, 16'h0001);
    check({15'h0, q_valid}, 16'h0001);
    q_ready <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check({15'h0, q_valid}, 16'h0000);
    test_done;
  end
endmodule // tb_rff_top

//--- verilog/rff_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rff_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr_reg;        // write index
  logic [AW-1:0]    rd_ptr_reg;        // read index
  logic [AW:0]      count_reg;         // fill level
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write, no reset needed for data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // rff_fifo

//--- verilog/rff_map.svh
// register offsets, field positions, reset values and timing counts for the receive filter
`ifndef RFF_MAP_SVH
`define RFF_MAP_SVH
`define RFF_ADDR_W            8
`define RFF_OFS_RX_CTRL       8'h04
`define RFF_OFS_TXQ_FREE      8'h08
`define RFF_OFS_STATION_LO    8'h10
`define RFF_OFS_STATION_MID   8'h12
`define RFF_OFS_STATION_HI    8'h14
`define RFF_OFS_HASH_0        8'h18
`define RFF_OFS_HASH_1        8'h1A
`define RFF_OFS_HASH_2        8'h1C
`define RFF_OFS_HASH_3        8'h1E
`define RFF_OFS_TXQ_CMD       8'h20
`define RFF_OFS_LINK_CFG      8'h22
`define RFF_OFS_RX_STAT       8'h24
`define RFF_RX_CTRL_WMASK     16'h06FD
`define RFF_BIT_PAUSE_EN      10
`define RFF_BIT_BAD_FCS_EN    9
`define RFF_BIT_BCAST_EN      7
`define RFF_BIT_MCAST_EN      6
`define RFF_BIT_STATION_EN    5
`define RFF_BIT_ANY_EN        4
`define RFF_BIT_DROP_FCS_EN   3
`define RFF_BIT_HASH_EN       2
`define RFF_BIT_RUN_EN        0
`define RFF_TXQ_TOTAL_BYTES   13'h1000
`define RFF_TXQ_CTRL_WORD     13'h0004
`define RFF_FREE_W            13
`define RFF_PAUSE_QUANTUM_BITS 512
`define RFF_BIT_TIME_NS       10
`define RFF_CLK_NS            10
`define RFF_QUANTUM_CYCLES    ((`RFF_PAUSE_QUANTUM_BITS * `RFF_BIT_TIME_NS) / `RFF_CLK_NS)
`define RFF_FCS_BYTES         4
`define RFF_FIFO_DEPTH        16
`define RFF_FIFO_WIDTH        9
`endif

//--- verilog/rff_pkg.sv
// types shared by the receive filter modules
package rff_pkg;
  typedef enum logic [1:0] {
    RFF_RX_STOPPED,
    RFF_RX_IDLE,
    RFF_RX_FRAME,
    RFF_RX_DISCARD
  } rff_rx_state_e;
  typedef logic [15:0] rff_word_t;
endpackage

//--- verilog/rff_top.sv
// receive frame filter, receive control, pause honouring and tx queue free report
// Function
// - full-duplex pause frame holds transmit until timer
// - bad fcs frames kept when enabled
// - bad fcs frames dropped when disabled
// - broadcast enable accepts all broadcasts
// - multicast enable accepts multicast including broadcast
// - unicast enable accepts station address match
// - accept-all takes every frame
// - strip enable removes fcs before storing
// - strip clear stores fcs after data
// - hash enable accepts hash-passing multicast
// - receive enable starts running state
// - clearing enable stops after current frame
// - free tx bytes in 13-bit field
// - free count includes payload and control word
//
// Added by the designer: the strobed register port.
`include "rff_map.svh"
`timescale 1ns/1ps
module rff_top
  import rff_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic        rx_fcs_bad,
  input  wire logic        rx_hash_hit,
  input  wire logic        pause_rx,
  input  wire logic [15:0] pause_quanta,
  input  wire logic        tx_frame_done,
  input  wire logic [12:0] tx_frame_bytes,
  output logic [7:0]       q_data,
  output logic             q_last,
  output logic             q_valid,
  input  wire logic        q_ready,
  output logic             rx_overflow,
  output logic             tx_hold,
  output logic             rx_running
);
  rff_word_t               rx_ctrl_reg;      // receive control register
  logic [47:0]             station_reg;      // station address
  logic [63:0]             hash_reg;         // multicast hash table bits (host software use)
  logic                    full_duplex_reg;  // link duplex setting
  logic [`RFF_FREE_W-1:0]  txq_free_reg;     // free tx queue bytes
  logic [15:0]             rx_stat_reg;      // accepted/dropped counters
  rff_rx_state_e           state_reg;        // receive state
  logic                    pass_first;       // store mode: first byte taken while idle
  logic                    pass_body;        // store mode: later bytes of the frame
  logic [47:0]             dest_shift_reg;   // destination address capture
  logic [2:0]              byte_cnt_reg;     // header byte index
  logic [7:0]              hold_reg [`RFF_FCS_BYTES]; // fcs delay line
  logic [2:0]              hold_cnt_reg;     // bytes held in delay line
  logic [15:0]             pause_cnt_reg;    // pause quanta remaining
  logic [15:0]             quantum_cnt_reg;  // cycles within a quantum
  logic [8:0]              fifo_in;
  logic                    fifo_in_valid;
  logic                    fifo_in_ready;
  logic [8:0]              fifo_out;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic                    wr_hit;
  logic                    addr_done;
  logic                    is_bcast;
  logic                    is_mcast;
  logic                    station_hit;
  logic                    admit;
  logic                    strip;
  logic [47:0]             dest_full;

  assign wr_hit = reg_wr;

  // software-visible register writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_ctrl_reg     <= 16'h0000;
      station_reg     <= 48'h0000_0000_0000;
      hash_reg        <= 64'h0;
      full_duplex_reg <= 1'b0;
    end else if (wr_hit) begin
      case (reg_addr)
        `RFF_OFS_RX_CTRL:     rx_ctrl_reg <= reg_wdata & `RFF_RX_CTRL_WMASK; // reserved bits stay 0
        `RFF_OFS_STATION_LO:  station_reg[15:0]  <= reg_wdata;
        `RFF_OFS_STATION_MID: station_reg[31:16] <= reg_wdata;
        `RFF_OFS_STATION_HI:  station_reg[47:32] <= reg_wdata;
        `RFF_OFS_HASH_0:      hash_reg[15:0]  <= reg_wdata;
        `RFF_OFS_HASH_1:      hash_reg[31:16] <= reg_wdata;
        `RFF_OFS_HASH_2:      hash_reg[47:32] <= reg_wdata;
        `RFF_OFS_HASH_3:      hash_reg[63:48] <= reg_wdata;
        `RFF_OFS_LINK_CFG:    full_duplex_reg <= reg_wdata[0];
        default: ;            // unmapped or read-only: ignored
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RFF_OFS_RX_CTRL:     reg_rdata <= rx_ctrl_reg;
        `RFF_OFS_TXQ_FREE:    reg_rdata <= {3'b000, txq_free_reg};
        `RFF_OFS_STATION_LO:  reg_rdata <= station_reg[15:0];
        `RFF_OFS_STATION_MID: reg_rdata <= station_reg[31:16];
        `RFF_OFS_STATION_HI:  reg_rdata <= station_reg[47:32];
        `RFF_OFS_HASH_0:      reg_rdata <= hash_reg[15:0];
        `RFF_OFS_HASH_1:      reg_rdata <= hash_reg[31:16];
        `RFF_OFS_HASH_2:      reg_rdata <= hash_reg[47:32];
        `RFF_OFS_HASH_3:      reg_rdata <= hash_reg[63:48];
        `RFF_OFS_LINK_CFG:    reg_rdata <= {15'h0000, full_duplex_reg};
        `RFF_OFS_RX_STAT:     reg_rdata <= rx_stat_reg;
        default:              reg_rdata <= 16'h0000; // unmapped reads zero
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // tx queue free bytes: writing a frame length to the command offset reserves
  // payload plus control word; completion returns the same amount
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txq_free_reg <= `RFF_TXQ_TOTAL_BYTES;
    end else begin
      case ({wr_hit && reg_addr == `RFF_OFS_TXQ_CMD, tx_frame_done})
        2'b10:   txq_free_reg <= txq_free_reg - reg_wdata[12:0] - `RFF_TXQ_CTRL_WORD;
        2'b01:   txq_free_reg <= txq_free_reg + tx_frame_bytes + `RFF_TXQ_CTRL_WORD;
        // reserve and release in one cycle: the two control words cancel
        2'b11:   txq_free_reg <= txq_free_reg - reg_wdata[12:0] + tx_frame_bytes;
        default: txq_free_reg <= txq_free_reg;
      endcase
    end
  end

  // address classification from the captured destination
  assign dest_full   = {dest_shift_reg[39:0], rx_data};
  assign is_bcast    = (dest_full == 48'hFFFF_FFFF_FFFF);
  assign is_mcast    = dest_full[40];          // group bit of first byte
  assign station_hit = (dest_full == station_reg) && !is_mcast;
  assign addr_done   = (state_reg == RFF_RX_FRAME) && rx_valid && (byte_cnt_reg == 3'd5);
  assign admit = rx_ctrl_reg[`RFF_BIT_ANY_EN]
               | (rx_ctrl_reg[`RFF_BIT_BCAST_EN] & is_bcast)
               | (rx_ctrl_reg[`RFF_BIT_MCAST_EN] & is_mcast)
               | (rx_ctrl_reg[`RFF_BIT_STATION_EN] & station_hit)
               | (rx_ctrl_reg[`RFF_BIT_HASH_EN] & is_mcast & rx_hash_hit);
  assign strip = rx_ctrl_reg[`RFF_BIT_DROP_FCS_EN];
  // store mode bypasses the delay line, so no byte of the fcs is lost at
  // the end of the frame and no drain phase is needed before the next one
  assign pass_first = !strip && rx_valid && rx_sof && (state_reg == RFF_RX_IDLE)
                    && rx_ctrl_reg[`RFF_BIT_RUN_EN];
  assign pass_body  = !strip && rx_valid && !rx_sof && (state_reg == RFF_RX_FRAME);

  // receive state: stop only between frames
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= RFF_RX_STOPPED;
    end else begin
      case (state_reg)
        RFF_RX_STOPPED: if (rx_ctrl_reg[`RFF_BIT_RUN_EN]) state_reg <= RFF_RX_IDLE;
        RFF_RX_IDLE: begin
          if (!rx_ctrl_reg[`RFF_BIT_RUN_EN]) begin
            state_reg <= RFF_RX_STOPPED;
          end else if (rx_valid && rx_sof) begin
            state_reg <= RFF_RX_FRAME;
          end
        end
        RFF_RX_FRAME: begin
          if (rx_valid && rx_eof) begin
            state_reg <= RFF_RX_IDLE;                 // frame finishes even if disabled
          end else if (addr_done && !admit) begin
            state_reg <= RFF_RX_DISCARD;
          end
        end
        RFF_RX_DISCARD: if (rx_valid && rx_eof) state_reg <= RFF_RX_IDLE;
        default: state_reg <= RFF_RX_STOPPED;
      endcase
    end
  end

  // destination capture and header count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dest_shift_reg <= 48'h0;
      byte_cnt_reg   <= 3'd0;
    end else if (rx_valid) begin
      if (rx_sof) begin
        dest_shift_reg <= {40'h0, rx_data};
        byte_cnt_reg   <= 3'd1;
      end else if (byte_cnt_reg != 3'd6) begin
        dest_shift_reg <= dest_full;
        byte_cnt_reg   <= byte_cnt_reg + 3'd1;
      end
    end
  end

  // fcs delay line: the last four bytes are held back so they can be stripped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_reg <= 3'd0;
      for (int i = 0; i < `RFF_FCS_BYTES; i++) hold_reg[i] <= 8'h00;
    end else if (rx_valid && (state_reg == RFF_RX_IDLE || state_reg == RFF_RX_FRAME)) begin
      hold_reg[0] <= rx_data;
      for (int i = 1; i < `RFF_FCS_BYTES; i++) hold_reg[i] <= hold_reg[i-1];
      if (rx_eof) begin
        hold_cnt_reg <= 3'd0;
      end else if (rx_sof) begin
        hold_cnt_reg <= 3'd1;
      end else if (hold_cnt_reg != 3'd4) begin
        hold_cnt_reg <= hold_cnt_reg + 3'd1;
      end
    end
  end

  // bytes into the fifo; unless bad-fcs keep is set, frames that fail the fcs check are cut with
  // a last marker so the consumer can discard the partial frame
  // strip mode runs four bytes behind the line so the fcs never enters;
  // store mode passes every byte straight through, fcs included
  // limitation: the filter verdict lands on the sixth byte, so the head of
  // a rejected frame may already be queued without a last marker
  always_comb begin
    fifo_in       = 9'h000;
    fifo_in_valid = 1'b0;
    if (state_reg == RFF_RX_FRAME && rx_valid && !rx_sof && rx_eof) begin
      begin
        if (rx_fcs_bad && !rx_ctrl_reg[`RFF_BIT_BAD_FCS_EN]) begin
          fifo_in       = {1'b1, 8'h00};              // mark frame as dropped
          fifo_in_valid = 1'b1;
        end else if (strip) begin
          fifo_in       = {1'b1, hold_reg[3]};        // fcs not stored
          fifo_in_valid = 1'b1;
        end else begin
          fifo_in       = {1'b1, rx_data};            // fcs follows the data
          fifo_in_valid = 1'b1;
        end
      end
    end else if (pass_first || pass_body) begin
      fifo_in       = {1'b0, rx_data};                // every byte stored
      fifo_in_valid = 1'b1;
    end else if (strip && state_reg == RFF_RX_FRAME && rx_valid && !rx_sof
                 && hold_cnt_reg == 3'd4) begin
      fifo_in       = {1'b0, hold_reg[3]};            // delayed byte
      fifo_in_valid = 1'b1;
    end
  end

  // overflow when fifo refuses a byte; acts as back-pressure report
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_overflow <= 1'b0;
    end else begin
      rx_overflow <= fifo_in_valid && !fifo_in_ready;
    end
  end

  // accepted and dropped frame counters
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_stat_reg <= 16'h0000;
    end else if (rx_valid && rx_eof && state_reg == RFF_RX_FRAME) begin
      rx_stat_reg[7:0] <= rx_stat_reg[7:0] + 8'h01;
    end else if (rx_valid && rx_eof && state_reg == RFF_RX_DISCARD) begin
      rx_stat_reg[15:8] <= rx_stat_reg[15:8] + 8'h01;
    end
  end

  rff_fifo #(
    .WIDTH (`RFF_FIFO_WIDTH),
    .DEPTH (`RFF_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // output stage register; drains when the consumer is ready
  assign fifo_out_ready = !q_valid || q_ready;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_valid <= 1'b0;
      q_data  <= 8'h00;
      q_last  <= 1'b0;
    end else if (fifo_out_ready) begin
      q_valid <= fifo_out_valid;
      q_data  <= fifo_out[7:0];
      q_last  <= fifo_out[8];
    end
  end

  // pause timer, honoured only in full duplex with pause honour enabled
  // a new pause frame reloads the count, so a zero quanta ends the hold early
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pause_cnt_reg   <= 16'h0000;
      quantum_cnt_reg <= 16'h0000;
    end else if (pause_rx && full_duplex_reg && rx_ctrl_reg[`RFF_BIT_PAUSE_EN]) begin
      pause_cnt_reg   <= pause_quanta;
      quantum_cnt_reg <= 16'h0000;
    end else if (pause_cnt_reg != 16'h0000) begin
      if (quantum_cnt_reg == 16'(`RFF_QUANTUM_CYCLES - 1)) begin
        quantum_cnt_reg <= 16'h0000;
        pause_cnt_reg   <= pause_cnt_reg - 16'h0001;
      end else begin
        quantum_cnt_reg <= quantum_cnt_reg + 16'h0001;
      end
    end
  end

  // registered status outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_hold    <= 1'b0;
      rx_running <= 1'b0;
    end else begin
      tx_hold    <= (pause_cnt_reg != 16'h0000);
      rx_running <= (state_reg != RFF_RX_STOPPED);
    end
  end
endmodule // rff_top
